// File: rtl/bms_mode_sequencer.sv
// mode sequencer of an adaptive half-bridge lamp ballast controller
//
// Overview of operation
// - in lockout both gates stay low and the control node is grounded
// - supply above upper threshold starts sweep and charging of the node
// - the first gate pulse after lockout is always on the low side
// - high side stays off until floating supply is above its threshold
// - sweep ends at the 6V control clamp, settling at minimum frequency
// - run mode holds frequency, changed only by zero-voltage corrections
// - in run mode, midpoint not at ground when low side turns on gives one sink pulse
// - in sweep and run, outside sink pulses the control node is slowly recharged
// - current sampled only in low on-time; sense switch only midpoint low
// - peak over five times average in low on-time latches fault
// - every hard-switched cycle in run mode gets its own correction pulse; none in sweep
// - control voltage below 1V latches fault, gates low
// - fault left only through lockout, then sweep starts again
// - both protections armed once control passes 4.6V in sweep
// - in fault the minimum-frequency pin is driven to zero
// - lockout uses hysteresis between upper and lower supply flags
`timescale 1ns/1ps
`include "bms_map.svh"
module bms_mode_sequencer
  import bms_pkg::*;
(
  // clock and reset
  input  wire logic  clk_i,
  input  wire logic  resetn_i,
  // supply comparators
  input  wire logic  supply_above_on_i,
  input  wire logic  supply_below_off_i,
  input  wire logic  floating_supply_on_threshold_i,
  // half-bridge midpoint and current comparators
  input  wire logic  bridge_midpoint_sense_low_i,
  input  wire logic  peak_over_average_i,
  // control node comparators
  input  wire logic  ctrl_at_clamp_i,
  input  wire logic  ctrl_above_arm_i,
  input  wire logic  ctrl_below_shutdown_i,
  // oscillator timing reference, high in the high-side half
  input  wire logic  osc_phase_high_i,
  // gate drive
  output logic       high_side_gate_out_o,
  output logic       low_side_gate_out_o,
  // control node drive
  output logic       ctrl_node_reset_o,
  output logic       ctrl_node_charge_o,
  output logic       ctrl_node_sink_o,
  // current sense
  output logic       sense_switch_on_o,
  output logic       current_sample_o,
  // status
  output logic       min_frequency_zero_o,
  output logic       supply_lockout_state_o,
  output logic       protect_armed_o,
  output bms_mode_t  mode_o
);

  logic [1:0]             rst_pipe_reg;
  logic                   rst_n;
  logic [`BMS_NFLAGS-1:0] raw;
  logic [`BMS_NFLAGS-1:0] s1_reg;
  logic [`BMS_NFLAGS-1:0] s2_reg;
  logic [`BMS_NFLAGS-1:0] s3_reg;
  logic [`BMS_NFLAGS-1:0] flt_reg;
  logic                   sup_on;
  logic                   sup_off;
  logic                   float_ok;
  logic                   mid_low;
  logic                   at_clamp;
  logic                   above_arm;
  logic                   below_sd;
  logic                   crest;
  logic                   phase_hi;
  bms_mode_t              mode_reg;
  bms_mode_t              mode_next;
  logic                   lockout_reg;
  logic                   armed_reg;
  logic                   lo_seen_reg;
  logic                   active;
  logic                   trip;
  logic [`BMS_SINK_W-1:0] sink_cnt_reg;
  logic                   ctrl_reset_reg;
  logic                   ctrl_charge_reg;
  logic                   ctrl_sink_reg;
  logic                   hi_gate_reg;
  logic                   lo_gate_reg;
  logic                   sense_reg;
  logic                   sample_reg;
  logic                   min_frequency_set_zero_reg;

  bms_gate_if lo_if ();
  bms_gate_if hi_if ();

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_reg[1];

  // gather the asynchronous comparator flags
  assign raw[`BMS_F_SUP_ON]   = supply_above_on_i;
  assign raw[`BMS_F_SUP_OFF]  = supply_below_off_i;
  assign raw[`BMS_F_FLOAT_OK] = floating_supply_on_threshold_i;
  assign raw[`BMS_F_MID_LOW]  = bridge_midpoint_sense_low_i;
  assign raw[`BMS_F_CLAMP]    = ctrl_at_clamp_i;
  assign raw[`BMS_F_ARM]      = ctrl_above_arm_i;
  assign raw[`BMS_F_SHUTDOWN] = ctrl_below_shutdown_i;
  assign raw[`BMS_F_CREST]    = peak_over_average_i;
  assign raw[`BMS_F_PHASE_HI] = osc_phase_high_i;

  // three-flop chain; a flag moves only when stages two and three agree,
  // which keeps a comparator chattering on its edge from reaching the fsm
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg  <= 9'h000;
      s2_reg  <= 9'h000;
      s3_reg  <= 9'h000;
      flt_reg <= 9'h000;
    end else begin
      s1_reg  <= raw;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      flt_reg <= (s2_reg & s3_reg) | (flt_reg & (s2_reg | s3_reg));
    end
  end

  assign sup_on    = flt_reg[`BMS_F_SUP_ON];
  assign sup_off   = flt_reg[`BMS_F_SUP_OFF];
  assign float_ok  = flt_reg[`BMS_F_FLOAT_OK];
  assign mid_low   = flt_reg[`BMS_F_MID_LOW];
  assign at_clamp  = flt_reg[`BMS_F_CLAMP];
  assign above_arm = flt_reg[`BMS_F_ARM];
  assign below_sd  = flt_reg[`BMS_F_SHUTDOWN];
  assign crest     = flt_reg[`BMS_F_CREST];
  assign phase_hi  = flt_reg[`BMS_F_PHASE_HI];

  // supply lockout with hysteresis; the low flag wins if both stand
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lockout_reg <= 1'b1;
    end else if (sup_off) begin
      lockout_reg <= 1'b1;
    end else if (sup_on) begin
      lockout_reg <= 1'b0;
    end
  end

  assign active = (mode_reg == MODE_SWEEP) || (mode_reg == MODE_RUN);
  // either protection trips only once armed
  assign trip = armed_reg && ((lo_if.on && crest) || below_sd);

  // mode selection; lockout overrides every other mode
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      MODE_LOCKOUT: begin
        if (!lockout_reg) begin
          mode_next = MODE_SWEEP;
        end
      end
      MODE_SWEEP: begin
        if (lockout_reg) begin
          mode_next = MODE_LOCKOUT;
        end else if (trip) begin
          mode_next = MODE_FAULT;
        end else if (at_clamp) begin
          mode_next = MODE_RUN;
        end
      end
      MODE_RUN: begin
        if (lockout_reg) begin
          mode_next = MODE_LOCKOUT;
        end else if (trip) begin
          mode_next = MODE_FAULT;
        end
      end
      MODE_FAULT: begin
        if (lockout_reg) begin
          mode_next = MODE_LOCKOUT;
        end
      end
    endcase
  end

  // mode register
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= MODE_LOCKOUT;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // arming: set on first pass of the arm level in sweep, kept until lockout
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      armed_reg <= 1'b0;
    end else if (mode_reg == MODE_LOCKOUT) begin
      armed_reg <= 1'b0;
    end else if ((mode_reg == MODE_SWEEP) && above_arm) begin
      armed_reg <= 1'b1;
    end
  end

  // remembers that the low side has pulsed since lockout
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lo_seen_reg <= 1'b0;
    end else if (mode_reg == MODE_LOCKOUT) begin
      lo_seen_reg <= 1'b0;
    end else if (lo_if.start) begin
      lo_seen_reg <= 1'b1;
    end
  end

  // gate requests; high side waits for a low pulse and its own supply
  assign lo_if.req = active && !phase_hi;
  assign hi_if.req = active && phase_hi && lo_seen_reg && float_ok;

  bms_dead_timer #(
    .DELAY (10'(`BMS_DT_LO_CYC))
  ) u_lo_timer (
    .clk_i  (clk_i),
    .rst_ni (rst_n),
    .gate   (lo_if)
  );

  bms_dead_timer #(
    .DELAY (10'(`BMS_DT_HO_CYC))
  ) u_hi_timer (
    .clk_i  (clk_i),
    .rst_ni (rst_n),
    .gate   (hi_if)
  );

  // correction pulse: midpoint still high as the low side turns on;
  // cut short if run mode is left so no stale sink outlives it
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sink_cnt_reg <= 6'h00;
    end else if (mode_reg != MODE_RUN) begin
      sink_cnt_reg <= 6'h00;
    end else if (lo_if.start && !mid_low) begin
      sink_cnt_reg <= 6'(`BMS_ZVS_PULSE_CYC);
    end else if (sink_cnt_reg != 6'h00) begin
      sink_cnt_reg <= sink_cnt_reg - 6'h01;
    end
  end

  // control node drive, registered straight to the pins
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reset_reg  <= 1'b1;
      ctrl_charge_reg <= 1'b0;
      ctrl_sink_reg   <= 1'b0;
    end else begin
      ctrl_reset_reg  <= (mode_reg == MODE_LOCKOUT);
      ctrl_charge_reg <= active && (sink_cnt_reg == 6'h00);
      ctrl_sink_reg   <= (sink_cnt_reg != 6'h00);
    end
  end

  // gate outputs, forced low outside sweep and run
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hi_gate_reg <= 1'b0;
      lo_gate_reg <= 1'b0;
    end else begin
      hi_gate_reg <= hi_if.on && active;
      lo_gate_reg <= lo_if.on && active;
    end
  end

  // current sense window follows the low-side on-time only
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sample_reg <= 1'b0;
      sense_reg  <= 1'b0;
    end else begin
      sample_reg <= lo_if.on && active;
      sense_reg  <= lo_if.on && active && mid_low;
    end
  end

  // minimum-frequency pin pulled to zero while faulted
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      min_frequency_set_zero_reg <= 1'b0;
    end else begin
      min_frequency_set_zero_reg <= (mode_reg == MODE_FAULT);
    end
  end

  assign high_side_gate_out_o   = hi_gate_reg;
  assign low_side_gate_out_o    = lo_gate_reg;
  assign ctrl_node_reset_o      = ctrl_reset_reg;
  assign ctrl_node_charge_o     = ctrl_charge_reg;
  assign ctrl_node_sink_o       = ctrl_sink_reg;
  assign sense_switch_on_o      = sense_reg;
  assign current_sample_o       = sample_reg;
  assign min_frequency_zero_o   = min_frequency_set_zero_reg;
  assign supply_lockout_state_o = lockout_reg;
  assign protect_armed_o        = armed_reg;
  assign mode_o                 = mode_reg;

  // checks on the sequencer
  property p_lockout_quiet;
    @(posedge clk_i) disable iff (!rst_n)
    (mode_reg == MODE_LOCKOUT) |=> (!high_side_gate_out_o &&
      !low_side_gate_out_o && ctrl_node_reset_o);
  endproperty
  a_lockout_quiet: assert property (p_lockout_quiet)
    else $error("gates active or node not reset in lockout");

  property p_start_sweep;
    @(posedge clk_i) disable iff (!rst_n)
    (mode_reg == MODE_LOCKOUT && !lockout_reg) |=>
      (mode_reg == MODE_SWEEP) ##1 ctrl_node_charge_o;
  endproperty
  a_start_sweep: assert property (p_start_sweep)
    else $error("sweep or charging did not start");

  property p_low_first;
    @(posedge clk_i) disable iff (!rst_n)
    high_side_gate_out_o |-> lo_seen_reg;
  endproperty
  a_low_first: assert property (p_low_first)
    else $error("high side pulsed before low side");

  property p_float_gate;
    @(posedge clk_i) disable iff (!rst_n)
    (!float_ok) [*3] |-> !high_side_gate_out_o;
  endproperty
  a_float_gate: assert property (p_float_gate)
    else $error("high side on without floating supply");

  property p_clamp_run;
    @(posedge clk_i) disable iff (!rst_n)
    (mode_reg == MODE_SWEEP && !lockout_reg && !trip && at_clamp) |=>
      (mode_reg == MODE_RUN);
  endproperty
  a_clamp_run: assert property (p_clamp_run)
    else $error("clamp did not enter run");

  property p_zvs_pulse;
    @(posedge clk_i) disable iff (!rst_n)
    (mode_reg == MODE_RUN && lo_if.start && !mid_low) |->
      ##2 ctrl_node_sink_o;
  endproperty
  a_zvs_pulse: assert property (p_zvs_pulse)
    else $error("no sink pulse after hard switching");

  property p_charge_excl;
    @(posedge clk_i) disable iff (!rst_n)
    ctrl_node_sink_o |-> !ctrl_node_charge_o;
  endproperty
  a_charge_excl: assert property (p_charge_excl)
    else $error("charge and sink together");

  property p_sense_window;
    @(posedge clk_i) disable iff (!rst_n)
    sense_switch_on_o |-> (current_sample_o && $past(mid_low));
  endproperty
  a_sense_window: assert property (p_sense_window)
    else $error("sense switch outside low on-time");

  property p_crest_fault;
    @(posedge clk_i) disable iff (!rst_n)
    (active && !lockout_reg && armed_reg && lo_if.on && crest) |=>
      (mode_reg == MODE_FAULT) ##1 !low_side_gate_out_o;
  endproperty
  a_crest_fault: assert property (p_crest_fault)
    else $error("crest factor did not latch fault");

  property p_low_ctrl_fault;
    @(posedge clk_i) disable iff (!rst_n)
    (active && !lockout_reg && armed_reg && below_sd) |=>
      (mode_reg == MODE_FAULT);
  endproperty
  a_low_ctrl_fault: assert property (p_low_ctrl_fault)
    else $error("low control voltage did not latch fault");

  property p_fault_held;
    @(posedge clk_i) disable iff (!rst_n)
    (mode_reg == MODE_FAULT && !lockout_reg) |=> (mode_reg == MODE_FAULT);
  endproperty
  a_fault_held: assert property (p_fault_held)
    else $error("fault left without lockout");

  property p_unarmed;
    @(posedge clk_i) disable iff (!rst_n)
    (mode_reg == MODE_SWEEP && !armed_reg) |=> (mode_reg != MODE_FAULT);
  endproperty
  a_unarmed: assert property (p_unarmed)
    else $error("fault before arming");

  property p_min_frequency_set_zero;
    @(posedge clk_i) disable iff (!rst_n)
    (mode_reg == MODE_FAULT) |=> min_frequency_zero_o;
  endproperty
  a_min_frequency_set_zero: assert property (p_min_frequency_set_zero)
    else $error("minimum-frequency pin not zero in fault");

  property p_hysteresis;
    @(posedge clk_i) disable iff (!rst_n)
    (lockout_reg && !sup_on) |=> lockout_reg;
  endproperty
  a_hysteresis: assert property (p_hysteresis)
    else $error("lockout left without upper threshold");

  property p_disarm;
    @(posedge clk_i) disable iff (!rst_n)
    (mode_reg == MODE_LOCKOUT) |=> !protect_armed_o;
  endproperty
  a_disarm: assert property (p_disarm)
    else $error("protections still armed after lockout");

endmodule // bms_mode_sequencer

// File: rtl/bms_map.svh
// timing counts, flag positions and analog levels of the mode sequencer
`ifndef BMS_MAP_SVH
`define BMS_MAP_SVH

// clock rate
`define BMS_CLK_MHZ        250

// least dead times before each gate turns on, rounded up to cycles
`define BMS_DT_LO_NS       1800
`define BMS_DT_HO_NS       2100
`define BMS_DT_LO_CYC      ((`BMS_DT_LO_NS * `BMS_CLK_MHZ + 999) / 1000)
`define BMS_DT_HO_CYC      ((`BMS_DT_HO_NS * `BMS_CLK_MHZ + 999) / 1000)
`define BMS_DT_W           10

// length of one correction sink pulse on the control node
`define BMS_ZVS_PULSE_NS   100
`define BMS_ZVS_PULSE_CYC  ((`BMS_ZVS_PULSE_NS * `BMS_CLK_MHZ + 999) / 1000)
`define BMS_SINK_W         6

// comparator levels, set in the analog front end
`define BMS_SUPPLY_ON_MV   12700
`define BMS_SUPPLY_OFF_MV  10000
`define BMS_FLOAT_ON_MV    9000
`define BMS_CTRL_CLAMP_MV  6000
`define BMS_CTRL_ARM_MV    4600
`define BMS_CTRL_SD_MV     1000
`define BMS_CREST_X10      50

// positions of the comparator flags in the synchroniser vector
`define BMS_F_SUP_ON       0
`define BMS_F_SUP_OFF      1
`define BMS_F_FLOAT_OK     2
`define BMS_F_MID_LOW      3
`define BMS_F_CLAMP        4
`define BMS_F_ARM          5
`define BMS_F_SHUTDOWN     6
`define BMS_F_CREST        7
`define BMS_F_PHASE_HI     8
`define BMS_NFLAGS         9

`endif

// File: rtl/bms_pkg.sv
// types shared by the mode sequencer modules
package bms_pkg;

  // operating modes of the ballast sequencer
  typedef enum logic [1:0] {
    MODE_LOCKOUT = 2'b00,
    MODE_SWEEP   = 2'b01,
    MODE_RUN     = 2'b10,
    MODE_FAULT   = 2'b11
  } bms_mode_t;

endpackage

// File: rtl/bms_gate_if.sv
// link between the sequencer and one dead-time gate timer
`timescale 1ns/1ps
interface bms_gate_if;
  logic req;    // gate wanted on
  logic on;     // gate on after dead time
  logic start;  // one-cycle pulse as the gate turns on

  modport ctrl  (output req, input on, input start);
  modport timer (input req, output on, output start);
endinterface

// File: rtl/bms_dead_timer.sv
// dead-time delay for one gate: turns on late, turns off at once
`timescale 1ns/1ps
`include "bms_map.svh"
module bms_dead_timer
  import bms_pkg::*;
#(
  parameter logic [`BMS_DT_W-1:0] DELAY = 10'h001
) (
  // clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_ni,
  // gate handshake
  bms_gate_if.timer   gate
);

  logic [`BMS_DT_W-1:0] cnt_reg;
  logic                 on_reg;
  logic                 start_reg;

  // count the dead time while the request stands
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      cnt_reg <= 10'h000;
    end else if (!gate.req || on_reg) begin
      cnt_reg <= 10'h000;
    end else begin
      cnt_reg <= cnt_reg + 10'h001;
    end
  end

  // on after the full delay; dropping the request ends it next edge
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      on_reg    <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      on_reg    <= gate.req && (on_reg || (cnt_reg == DELAY - 10'h001));
      start_reg <= gate.req && !on_reg && (cnt_reg == DELAY - 10'h001);
    end
  end

  assign gate.on    = on_reg;
  assign gate.start = start_reg;

endmodule // bms_dead_timer

// File: rtl/unused_placeholder.sv
// intentionally empty
`timescale 1ns/1ps

// File: bench/bms_bridge_model.sv
// half-bridge switches and resonant load, seen as the midpoint comparator
`timescale 1ns/1ps
module bms_bridge_model (
  // clock
  input  wire logic clk_i,
  // gate drive from the sequencer
  input  wire logic high_gate_i,
  input  wire logic low_gate_i,
  // bench command: midpoint fails to reach ground in dead time
  input  wire logic hard_switch_i,
  // midpoint at ground
  output logic      midpoint_low_o
);
  logic last_high_reg = 1'b0;

  // last conducting switch decides where the midpoint slews in dead time
  always_ff @(posedge clk_i) begin
    if (high_gate_i) begin
      last_high_reg <= 1'b1;
    end else if (low_gate_i) begin
      last_high_reg <= 1'b0;
    end
  end

  // after the high side the load current pulls the midpoint to ground,
  // unless hard switching is commanded; after the low side it swings up
  always_ff @(posedge clk_i) begin
    if (low_gate_i) begin
      midpoint_low_o <= 1'b1;
    end else if (high_gate_i) begin
      midpoint_low_o <= 1'b0;
    end else begin
      midpoint_low_o <= last_high_reg & ~hard_switch_i;
    end
  end
endmodule // bms_bridge_model

// File: bench/ballast_mode_sequencer_test.sv
// self-checking bench of the ballast mode sequencer
`timescale 1ns/1ps
module ballast_mode_sequencer_test;
  import bms_pkg::*;
  // stimulus
  logic      clk_i = 1'b0, resetn = 1'b0, sup_on = 1'b0, sup_off = 1'b0;
  logic      flt_ok = 1'b0, peak = 1'b0, clamp = 1'b0, arm = 1'b0;
  logic      sd = 1'b0, phase = 1'b0, hard = 1'b0, mid_low;
  // observed
  logic      hs, ls, nd_rst, nd_chg, nd_sink, sns, smp, fz, lock, armed;
  logic      seen_low = 1'b0, hs_prev = 1'b0, prev;
  bms_mode_t mode;
  int        num_errors = 0, checks_done = 0, half_cyc = 1000, ph_cnt = 0;
  int        cnt;

  always #2 clk_i = ~clk_i;

  bms_mode_sequencer dut (
    .clk_i(clk_i), .resetn_i(resetn), .supply_above_on_i(sup_on),
    .supply_below_off_i(sup_off), .floating_supply_on_threshold_i(flt_ok),
    .bridge_midpoint_sense_low_i(mid_low), .peak_over_average_i(peak),
    .ctrl_at_clamp_i(clamp), .ctrl_above_arm_i(arm),
    .ctrl_below_shutdown_i(sd), .osc_phase_high_i(phase),
    .high_side_gate_out_o(hs), .low_side_gate_out_o(ls),
    .ctrl_node_reset_o(nd_rst), .ctrl_node_charge_o(nd_chg),
    .ctrl_node_sink_o(nd_sink), .sense_switch_on_o(sns),
    .current_sample_o(smp), .min_frequency_zero_o(fz),
    .supply_lockout_state_o(lock), .protect_armed_o(armed), .mode_o(mode));

  bms_bridge_model bridge (.clk_i(clk_i), .high_gate_i(hs),
    .low_gate_i(ls), .hard_switch_i(hard), .midpoint_low_o(mid_low));

  // oscillator reference, half period drawn at random
  always @(posedge clk_i) begin
    if (ph_cnt >= half_cyc - 1) begin
      ph_cnt <= 0;
      phase  <= ~phase;
    end else begin
      ph_cnt <= ph_cnt + 1;
    end
  end

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // every high-side turn-on must follow a low pulse and a valid supply
  always @(negedge clk_i) begin
    if (mode === MODE_LOCKOUT) seen_low <= 1'b0;
    else if (ls === 1'b1) seen_low <= 1'b1;
    if (hs === 1'b1 && hs_prev !== 1'b1) begin
      check("low pulse first", 8'(seen_low), 8'h01);
      check("floating ok", 8'(flt_ok), 8'h01);
    end
    if (hs === 1'b1 && ls === 1'b1) check("both gates", 8'h01, 8'h00);
    hs_prev <= hs;
  end

  task automatic cyc(int n);
    repeat (n) @(posedge clk_i);
  endtask

  function automatic logic pick(int s);
    return (s == 0) ? ls : (s == 1) ? hs : nd_sink;
  endfunction

  // bounded waits sample at the falling edge, where flops have settled
  task automatic wait_lvl(int s, logic v, int lim);
    for (int i = 0; i < lim && pick(s) !== v; i++) @(negedge clk_i);
    if (pick(s) !== v) begin
      check("level wait", 8'(pick(s)), 8'(v));
      tally_and_finish();
    end
  endtask

  task automatic wait_mode(bms_mode_t m, int lim);
    for (int i = 0; i < lim && mode !== m; i++) @(negedge clk_i);
    if (mode !== m) begin
      check("mode wait", 8'(mode), 8'(m));
      tally_and_finish();
    end
  endtask

  initial begin
    void'($urandom(18663));
    half_cyc = 1000 + $urandom_range(200);
    cyc(16);
    resetn <= 1'b1;
    cyc(20);
    @(negedge clk_i);
    check("gates", 8'({hs, ls}), 8'h00);
    check("node reset", 8'(nd_rst), 8'h01);
    check("lockout mid band", 8'(lock), 8'h01);
    cyc(1);
    sup_on <= 1'b1;
    wait_mode(MODE_SWEEP, 20);
    cyc(3);
    @(negedge clk_i);
    check("charge sweep", 8'({nd_rst, nd_chg}), 8'h01);
    // protections ignored before the arm level is reached
    cyc(1);
    peak <= 1'b1;
    sd   <= 1'b1;
    cyc(3 * half_cyc + $urandom_range(300));
    @(negedge clk_i);
    check("unarmed mode", 8'(mode), 8'(MODE_SWEEP));
    check("unarmed", 8'(armed), 8'h00);
    check("low toggles", 8'(seen_low), 8'h01);
    cyc(1);
    {peak, sd} <= 2'b00;
    flt_ok <= 1'b1;
    arm    <= 1'b1;
    cyc(10);
    @(negedge clk_i);
    check("armed", 8'(armed), 8'h01);
    wait_lvl(1, 1'b1, 3 * half_cyc);
    cyc(1);
    clamp <= 1'b1;
    wait_mode(MODE_RUN, 30);
    // between thresholds the supply keeps the device running;
    // a one-cycle glitch on the low flag must not reach the lockout flop
    cyc(1);
    sup_on  <= 1'b0;
    sup_off <= 1'b1;
    cyc(1);
    sup_off <= 1'b0;
    cyc(30);
    @(negedge clk_i);
    check("run mid band", 8'(mode), 8'(MODE_RUN));
    check("glitch ignored", 8'(lock), 8'h00);
    cyc(1);
    sup_on <= 1'b1;
    cnt = 0;
    repeat (2 * half_cyc + 100) @(negedge clk_i) cnt += int'(nd_sink);
    check("no sink at zvs", 8'(cnt), 8'h00);
    check("charge run", 8'(nd_chg), 8'h01);
    wait_lvl(0, 1'b0, 3 * half_cyc);
    wait_lvl(0, 1'b1, 3 * half_cyc);
    repeat (100) @(negedge clk_i);
    check("sample low on", 8'({smp, sns}), 8'h03);
    wait_lvl(1, 1'b1, 3 * half_cyc);
    repeat (100) @(negedge clk_i);
    check("sample high on", 8'({smp, sns}), 8'h00);
    // hard switching: one sink pulse per affected cycle
    cyc(1);
    hard <= 1'b1;
    wait_lvl(2, 1'b1, 3 * half_cyc);
    for (cnt = 0; cnt < 100 && nd_sink === 1'b1; cnt++) begin
      if (cnt == 10) check("charge off", 8'(nd_chg), 8'h00);
      @(negedge clk_i);
    end
    check("sink width", 8'(cnt), 8'h19);
    repeat (5) @(negedge clk_i);
    check("recharge", 8'(nd_chg), 8'h01);
    cnt  = 0;
    prev = nd_sink;
    repeat (5000) @(negedge clk_i) begin
      if (nd_sink === 1'b1 && prev !== 1'b1) cnt++;
      prev = nd_sink;
    end
    check("pulses", 8'(cnt), 8'h02);
    cyc(1);
    hard <= 1'b0;
    peak <= 1'b1;
    wait_mode(MODE_FAULT, 3 * half_cyc);
    cyc(3);
    @(negedge clk_i);
    check("fault gates", 8'({hs, ls}), 8'h00);
    check("min freq zero", 8'(fz), 8'h01);
    cyc(1);
    peak <= 1'b0;
    cyc(200 + $urandom_range(300));
    @(negedge clk_i);
    check("fault latched", 8'(mode), 8'(MODE_FAULT));
    // grounded node drops the clamp and arm comparators as well
    cyc(1);
    sup_off <= 1'b1;
    sup_on  <= 1'b0;
    {clamp, arm} <= 2'b00;
    wait_mode(MODE_LOCKOUT, 20);
    cyc(3);
    @(negedge clk_i);
    check("disarmed", 8'(armed), 8'h00);
    check("node reset again", 8'(nd_rst), 8'h01);
    cyc(1);
    sup_off <= 1'b0;
    sup_on  <= 1'b1;
    wait_mode(MODE_SWEEP, 20);
    cyc(10);
    @(negedge clk_i);
    check("sweep again", 8'(mode), 8'(MODE_SWEEP));
    check("unarmed again", 8'(armed), 8'h00);
    cyc(1);
    sd  <= 1'b1;
    arm <= 1'b1;
    wait_mode(MODE_FAULT, 20);
    cyc(3);
    @(negedge clk_i);
    check("shutdown gates", 8'({hs, ls}), 8'h00);
    tally_and_finish();
  end
endmodule // ballast_mode_sequencer_test
